// *** core/psc_pkg.sv ***
// shared constants, types and carriers of the power state controller
`default_nettype none
package psc_pkg;
    // timing
    localparam int unsigned CLK_KHZ = 200_000;
    localparam int unsigned PD_HOLD_MS = 5;
    localparam int unsigned WAKE_MAX_MS = 20;
    // least hold time: exact product, so rounding up changes nothing
    localparam int unsigned PD_HOLD_CYC = PD_HOLD_MS * CLK_KHZ;
    // longest wake time: exact product, so rounding down changes nothing
    localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_MS * CLK_KHZ;
    localparam int unsigned POR_CYC = 16;
    localparam int unsigned CNT_W = 23;
    localparam int unsigned POR_W = 5;

    // host transaction header
    localparam int unsigned PFX_W = 2;
    localparam int unsigned ADDR_W = 22;
    localparam int unsigned HDR_W = 24;
    localparam int unsigned BITCNT_W = 5;
    localparam int unsigned OPC_W = 8;
    localparam int unsigned OPC_LSB = 14;
    localparam logic [1:0] PFX_READ = 2'h0;
    localparam logic [1:0] PFX_CMD = 2'h1;
    localparam logic [1:0] PFX_WRITE = 2'h2;
    localparam logic [1:0] PFX_UNDEF = 2'h3;
    localparam logic [21:0] WAKE_ADDR = 22'h000000;

    // host command opcodes
    localparam logic [7:0] CMD_STANDBY = 8'h41;
    localparam logic [7:0] CMD_SLEEP = 8'h45;
    localparam logic [7:0] CMD_PWRDOWN = 8'h50;

    // pin drive select, 4 mA on every group
    localparam logic [4:0] DRV_DEFAULT = 5'h00;

    // synchroniser lanes
    localparam int unsigned SYN_W = 5;
    localparam int unsigned SYN_PD = 0;
    localparam int unsigned SYN_SUP = 1;
    localparam int unsigned SYN_OSC = 2;
    localparam int unsigned SYN_WAKE = 3;
    localparam int unsigned SYN_CMD = 4;
    localparam logic [4:0] SYN_RST = 5'h01;

    typedef enum logic [2:0]
    {
        PSC_ST_PWRDN = 3'h0,
        PSC_ST_WAKE = 3'h1,
        PSC_ST_STANDBY = 3'h3,
        PSC_ST_ACTIVE = 3'h2,
        PSC_ST_SLEEP = 3'h6
    } psc_state_t;

    typedef struct packed
    {
        logic reg_en;
        logic osc_en;
        logic pll_en;
        logic core_clk_en;
        logic engine_en;
        logic core_rst_n;
    } psc_power_t;

    typedef struct packed
    {
        logic de;
        logic vsync;
        logic hsync;
        logic panel_enable_out;
        logic pclk;
        logic [17:0] rgb;
    } psc_panel_t;

    typedef struct packed
    {
        logic audio;
        logic audio_oe;
        logic backlight;
        logic [3:0] touch;
        logic [3:0] touch_oe;
    } psc_keep_t;

    typedef struct packed
    {
        logic int_oe;
        logic miso_oe;
        logic [1:0] gpio_oe;
        logic [4:0] drive_sel;
    } psc_hostio_t;
endpackage : psc_pkg
`default_nettype wire

// *** core/psc_sync3.sv ***
// three-stage synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module psc_sync3 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            sync_out <= RST;
        end
        else if (ce)
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < int'(WIDTH); i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : psc_sync3
`default_nettype wire

// *** core/psc_link.sv ***
// host serial link decoder on the host clock, reports wake reads and commands
`timescale 1ns/1ps
`default_nettype none
module psc_link (
    // link clock and resets
    input wire logic sclk,
    input wire logic arst_n,
    input wire logic cs_n,
    // serial data from host
    input wire logic mosi,
    // events toward the core clock domain
    output logic wake_tgl,
    output logic cmd_tgl,
    output logic [psc_pkg::OPC_W-1:0] cmd_opc
);
    logic frame_rst_n;
    logic [psc_pkg::HDR_W-2:0] sh_q;
    logic [psc_pkg::BITCNT_W-1:0] cnt_q;
    logic [psc_pkg::HDR_W-1:0] hdr;
    logic last_bit;

    // the frame's own select ends it; the host clock may stop between frames
    assign frame_rst_n = arst_n & ~cs_n;
    assign hdr = {sh_q, mosi};
    assign last_bit = (cnt_q == psc_pkg::BITCNT_W'(psc_pkg::HDR_W - 1));

    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            sh_q <= '0;
            cnt_q <= '0;
        end
        else if (cnt_q != psc_pkg::BITCNT_W'(psc_pkg::HDR_W))
        begin
            sh_q <= hdr[psc_pkg::HDR_W-2:0];
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // prefix then 22-bit address; data bits after the header are not ours
    always_ff @(posedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_tgl <= 1'b0;
            cmd_tgl <= 1'b0;
            cmd_opc <= '0;
        end
        else if (!cs_n && last_bit)
        begin
            if (hdr[psc_pkg::HDR_W-1 -: psc_pkg::PFX_W] == psc_pkg::PFX_READ &&
                hdr[psc_pkg::ADDR_W-1:0] == psc_pkg::WAKE_ADDR)
            begin
                wake_tgl <= ~wake_tgl;
            end
            else if (hdr[psc_pkg::HDR_W-1 -: psc_pkg::PFX_W] == psc_pkg::PFX_CMD)
            begin
                cmd_opc <= hdr[psc_pkg::OPC_LSB +: psc_pkg::OPC_W];
                cmd_tgl <= ~cmd_tgl;
            end
        end
    end
endmodule : psc_link
`default_nettype wire

// *** core/psc_top.sv ***
// power state controller: state sequencing, clock and regulator gating, pin states
`timescale 1ns/1ps
`default_nettype none
module psc_top #(
    parameter int unsigned PD_HOLD_CYC = psc_pkg::PD_HOLD_CYC,
    parameter int unsigned WAKE_MAX_CYC = psc_pkg::WAKE_MAX_CYC,
    parameter int unsigned POR_CYC = psc_pkg::POR_CYC
) (
    // core clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // host serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    // analog status and power-down pin
    input wire logic powerdown_pin_low_n,
    input wire logic core_supply_ok,
    input wire logic osc_pll_ready,
    // pin values from the engines
    input wire psc_pkg::psc_panel_t panel_in,
    input wire psc_pkg::psc_keep_t keep_in,
    input wire psc_pkg::psc_hostio_t hostio_in,
    // power controls and state
    output psc_pkg::psc_power_t power_q,
    output psc_pkg::psc_state_t state_q,
    // pin values to the pads
    output psc_pkg::psc_panel_t panel_q,
    output psc_pkg::psc_keep_t keep_q,
    output psc_pkg::psc_hostio_t hostio_q
);
    logic wake_tgl;
    logic cmd_tgl;
    logic [psc_pkg::OPC_W-1:0] cmd_opc;
    logic [psc_pkg::SYN_W-1:0] syn;
    logic pd_low;
    logic pd_low_q;
    logic pd_rise;
    logic wake_s_q;
    logic cmd_s_q;
    logic wake_evt;
    logic cmd_evt;
    logic [psc_pkg::CNT_W-1:0] hold_cnt_q;
    logic pd_long_q;
    logic cmd_pd_q;
    logic pd_cmd;
    logic [psc_pkg::CNT_W-1:0] wait_cnt_q;
    logic wait_done;
    logic [psc_pkg::POR_W-1:0] por_cnt_q;
    logic por_done;
    logic in_reset_d;
    psc_pkg::psc_state_t state_d;
    psc_pkg::psc_power_t power_d;
    // link side runs on the host clock
    psc_link u_link (
        .sclk(sclk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .mosi(mosi),
        .wake_tgl(wake_tgl),
        .cmd_tgl(cmd_tgl),
        .cmd_opc(cmd_opc)
    );
    // pin, analog levels and link toggles all arrive from other domains
    psc_sync3 #(
        .WIDTH(psc_pkg::SYN_W),
        .RST(psc_pkg::SYN_RST)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .async_in({cmd_tgl, wake_tgl, osc_pll_ready, core_supply_ok, powerdown_pin_low_n}),
        .sync_out(syn)
    );
    assign pd_low = ~syn[psc_pkg::SYN_PD];
    assign pd_rise = pd_low_q & ~pd_low;
    assign wake_evt = syn[psc_pkg::SYN_WAKE] ^ wake_s_q;
    assign cmd_evt = syn[psc_pkg::SYN_CMD] ^ cmd_s_q;
    assign wait_done = (wait_cnt_q == psc_pkg::CNT_W'(WAKE_MAX_CYC - 1));
    assign por_done = (por_cnt_q == psc_pkg::POR_W'(POR_CYC));
    assign pd_cmd = (state_q == psc_pkg::PSC_ST_ACTIVE) && cmd_evt && (cmd_opc == psc_pkg::CMD_PWRDOWN);
    // event detection on synchronised levels
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pd_low_q <= 1'b0;
            wake_s_q <= 1'b0;
            cmd_s_q <= 1'b0;
        end
        else if (ce)
        begin
            pd_low_q <= pd_low;
            wake_s_q <= syn[psc_pkg::SYN_WAKE];
            cmd_s_q <= syn[psc_pkg::SYN_CMD];
        end
    end
    // measures how long the power-down pin has been held low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_cnt_q <= '0;
            pd_long_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!pd_low)
            begin
                hold_cnt_q <= '0;
                pd_long_q <= 1'b0;
            end
            else if (hold_cnt_q == psc_pkg::CNT_W'(PD_HOLD_CYC - 1))
            begin
                pd_long_q <= 1'b1;
            end
            else
            begin
                hold_cnt_q <= hold_cnt_q + 1'b1;
            end
        end
    end
    // remembers powerdown entered by command, so the regulator drops at once
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_pd_q <= 1'b0;
        end
        else if (ce)
        begin
            cmd_pd_q <= (cmd_pd_q | pd_cmd) & (state_d != psc_pkg::PSC_ST_WAKE);
        end
    end
    // next state
    always_comb
    begin
        state_d = state_q;
        if (pd_low)
        begin
            state_d = psc_pkg::PSC_ST_PWRDN;
        end
        else
        begin
            case (state_q)
                psc_pkg::PSC_ST_PWRDN:
                begin
                    if (pd_rise)
                    begin
                        state_d = psc_pkg::PSC_ST_WAKE;
                    end
                end
                psc_pkg::PSC_ST_WAKE:
                begin
                    if (por_done && (syn[psc_pkg::SYN_OSC] || wait_done))
                    begin
                        state_d = psc_pkg::PSC_ST_STANDBY;
                    end
                end
                psc_pkg::PSC_ST_STANDBY, psc_pkg::PSC_ST_SLEEP:
                begin
                    if (wake_evt)
                    begin
                        state_d = psc_pkg::PSC_ST_ACTIVE;
                    end
                end
                psc_pkg::PSC_ST_ACTIVE:
                begin
                    if (cmd_evt)
                    begin
                        case (cmd_opc)
                            psc_pkg::CMD_STANDBY: state_d = psc_pkg::PSC_ST_STANDBY;
                            psc_pkg::CMD_SLEEP: state_d = psc_pkg::PSC_ST_SLEEP;
                            psc_pkg::CMD_PWRDOWN: state_d = psc_pkg::PSC_ST_PWRDN;
                            default: state_d = state_q;
                        endcase
                    end
                end
                default:
                begin
                    state_d = psc_pkg::PSC_ST_WAKE;
                end
            endcase
        end
    end
    // reset wakes through the power-up sequence, never straight to active
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= psc_pkg::PSC_ST_WAKE;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end
    // bounds the wait for oscillator and PLL after a pin release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_cnt_q <= '0;
        end
        else if (ce)
        begin
            if (state_q != psc_pkg::PSC_ST_WAKE)
            begin
                wait_cnt_q <= '0;
            end
            else if (!wait_done)
            begin
                wait_cnt_q <= wait_cnt_q + 1'b1;
            end
        end
    end
    // power-on reset pulse once the core supply is above threshold
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            por_cnt_q <= '0;
        end
        else if (ce)
        begin
            if (state_q == psc_pkg::PSC_ST_PWRDN || !syn[psc_pkg::SYN_SUP])
            begin
                por_cnt_q <= '0;
            end
            else if (state_q == psc_pkg::PSC_ST_WAKE && !por_done)
            begin
                por_cnt_q <= por_cnt_q + 1'b1;
            end
        end
    end
    // power controls follow the next state so they change with it
    always_comb
    begin
        power_d = '{reg_en: power_q.reg_en, osc_en: 1'b0, pll_en: 1'b0, core_clk_en: 1'b0, engine_en: 1'b0,
                    core_rst_n: 1'b1};
        case (state_d)
            psc_pkg::PSC_ST_ACTIVE:
            begin
                power_d.osc_en = 1'b1;
                power_d.pll_en = 1'b1;
                power_d.core_clk_en = 1'b1;
                power_d.engine_en = 1'b1;
            end
            psc_pkg::PSC_ST_STANDBY:
            begin
                power_d.osc_en = 1'b1;
                power_d.pll_en = 1'b1;
            end
            psc_pkg::PSC_ST_WAKE:
            begin
                power_d.reg_en = 1'b1;
                power_d.osc_en = 1'b1;
                power_d.pll_en = 1'b1;
                power_d.core_rst_n = por_done;
            end
            psc_pkg::PSC_ST_PWRDN:
            begin
                // a short pin pulse leaves the regulator up: the decoupling is not yet drained
                power_d.reg_en = power_q.reg_en & ~(cmd_pd_q | pd_cmd | pd_long_q);
                power_d.core_rst_n = 1'b0;
            end
            default:
            begin
                // sleep: everything stopped, registers kept by the retained supply
                power_d.core_rst_n = 1'b1;
            end
        endcase
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_q <= '{reg_en: 1'b1, osc_en: 1'b1, pll_en: 1'b1, core_clk_en: 1'b0,
                         engine_en: 1'b0, core_rst_n: 1'b0};
        end
        else if (ce)
        begin
            power_q <= power_d;
        end
    end
    assign in_reset_d = (state_d == psc_pkg::PSC_ST_WAKE) && !por_done;
    // display outputs: follow the engines in active, low in powerdown, else held
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            panel_q <= '0;
        end
        else if (ce)
        begin
            if (state_d == psc_pkg::PSC_ST_PWRDN)
            begin
                panel_q <= '0;
            end
            else if (state_d == psc_pkg::PSC_ST_ACTIVE)
            begin
                panel_q <= panel_in;
            end
        end
    end
    // audio, backlight and touch pins keep their level outside active
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            keep_q <= '0;
        end
        else if (ce)
        begin
            if (state_d == psc_pkg::PSC_ST_ACTIVE && state_q == psc_pkg::PSC_ST_ACTIVE)
            begin
                keep_q <= keep_in;
            end
        end
    end
    // host-side pads: released and default strength during the power-on reset in wake; held in powerdown
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hostio_q <= '{int_oe: 1'b0, miso_oe: 1'b0, gpio_oe: 2'h0, drive_sel: psc_pkg::DRV_DEFAULT};
        end
        else if (ce)
        begin
            if (in_reset_d)
            begin
                hostio_q <= '{int_oe: 1'b0, miso_oe: 1'b0, gpio_oe: 2'h0,
                              drive_sel: psc_pkg::DRV_DEFAULT};
            end
            else if (state_d == psc_pkg::PSC_ST_ACTIVE)
            begin
                hostio_q <= hostio_in;
            end
        end
    end
endmodule : psc_top
`default_nettype wire

// *** tb/psc_assertions.sv ***
// port assertions of the power state controller
`timescale 1ns/1ps
`default_nettype none
module psc_assertions #(
    parameter int unsigned POR_CYC = 16
) (
    // watched ports
    input wire logic clk,
    input wire logic arst_n,
    input wire logic powerdown_pin_low_n,
    input wire psc_pkg::psc_power_t power_q,
    input wire psc_pkg::psc_state_t state_q,
    input wire psc_pkg::psc_panel_t panel_q,
    input wire psc_pkg::psc_keep_t keep_q
);
    localparam psc_pkg::psc_state_t ACT = psc_pkg::PSC_ST_ACTIVE;
    localparam psc_pkg::psc_state_t SBY = psc_pkg::PSC_ST_STANDBY;
    localparam psc_pkg::psc_state_t SLP = psc_pkg::PSC_ST_SLEEP;
    localparam psc_pkg::psc_state_t PD = psc_pkg::PSC_ST_PWRDN;
    // cycles spent with core reset held low
    logic [15:0] low_q;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            low_q <= '0;
        else
            low_q <= power_q.core_rst_n ? 16'h0 : low_q + 16'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_active_run:
    assert property (state_q == ACT |-> power_q.osc_en && power_q.pll_en && power_q.core_clk_en && power_q.engine_en)
        else $error("clocks off while active");
    a_standby_gate:
    assert property (state_q == SBY |-> power_q.osc_en && power_q.pll_en && !power_q.core_clk_en && !power_q.engine_en)
        else $error("standby gating wrong");
    a_sleep_off:
    assert property (state_q == SLP |-> !(power_q.osc_en || power_q.pll_en || power_q.core_clk_en))
        else $error("sleep clocks running");
    a_pwrdn_panel_low:
    assert property (state_q == PD && $past(state_q) == PD |-> panel_q == '0)
        else $error("panel not low in powerdown");
    a_lowpwr_pins_held:
    assert property ((state_q == SBY || state_q == SLP) && $past(state_q) == state_q |-> $stable(panel_q) && $stable(keep_q))
        else $error("pins moved in low power");
    a_pwrdn_keep_held:
    assert property (state_q == PD && $past(state_q) == PD |-> $stable(keep_q))
        else $error("kept pins moved in powerdown");
    a_reg_by_pin:
    assert property ($rose(power_q.reg_en) |-> powerdown_pin_low_n)
        else $error("regulator enabled without pin");
    a_pin_forces_pd:
    assert property ($fell(powerdown_pin_low_n) |-> ##[1:8] state_q == PD)
        else $error("pin low did not power down");
    a_por_long:
    assert property ($rose(power_q.core_rst_n) |-> low_q >= POR_CYC)
        else $error("power-on reset too short");
    a_wake_bound:
    assert property ($rose(powerdown_pin_low_n) && state_q == PD |-> ##[1:300] state_q == SBY)
        else $error("no standby after pin release");
    c_active: cover property (state_q == ACT);
    c_sleep: cover property (state_q == SLP);
    c_reg_on: cover property ($rose(power_q.reg_en));
endmodule : psc_assertions
bind psc_top psc_assertions #(.POR_CYC(POR_CYC)) u_chk (.clk, .arst_n, .powerdown_pin_low_n, .power_q, .state_q,
    .panel_q, .keep_q);
`default_nettype wire

// *** tb/psc_host.sv ***
// host serial port model, clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module psc_host (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    initial
    begin
        sclk = 1'b0;
        // select low across the reset edge so the frame counter is cleared as well
        cs_n = 1'b0;
        mosi = 1'b0;
        #2 cs_n = 1'b1;
    end
    // one header, msb first, 80 ns bit period
    task automatic frame(input logic [23:0] hdr);
        #63;
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            mosi = hdr[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #20 cs_n = 1'b1;
        mosi = ~mosi;
    endtask : frame
endmodule : psc_host
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the power state controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("Error t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module testbench;
    localparam int unsigned HOLD = 50;
    localparam logic [23:0] WAKE = {psc_pkg::PFX_READ, psc_pkg::WAKE_ADDR};
    logic clk = 1'b0;
    logic arst_n = 1'b1;
    logic powerdown_pin_low_n = 1'b1;
    logic core_supply_ok = 1'b0;
    logic osc_pll_ready = 1'b1;
    logic sclk;
    logic cs_n;
    logic mosi;
    psc_pkg::psc_panel_t panel_in = 23'h0;
    psc_pkg::psc_keep_t keep_in = 11'h0;
    psc_pkg::psc_hostio_t hostio_in = 9'h1f3;
    psc_pkg::psc_power_t power_q;
    psc_pkg::psc_state_t state_q;
    psc_pkg::psc_panel_t panel_q;
    psc_pkg::psc_panel_t exp_p;
    psc_pkg::psc_keep_t keep_q;
    psc_pkg::psc_keep_t exp_k;
    psc_pkg::psc_hostio_t hostio_q;
    int errors = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    psc_host u_host (.sclk, .cs_n, .mosi);
    psc_top #(.PD_HOLD_CYC(HOLD), .WAKE_MAX_CYC(200), .POR_CYC(16)) dut (.clk, .arst_n, .ce(1'b1), .sclk, .cs_n,
        .mosi, .powerdown_pin_low_n, .core_supply_ok, .osc_pll_ready, .panel_in, .keep_in, .hostio_in, .power_q,
        .state_q, .panel_q, .keep_q, .hostio_q);
    function automatic logic [23:0] cmd(input logic [7:0] opc);
        return {psc_pkg::PFX_CMD, opc, 14'h0};
    endfunction : cmd
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // waits a bounded time for a state, then checks it
    task automatic wait_st(input psc_pkg::psc_state_t st, input int lim);
        int k = 0;
        while (state_q !== st && k < lim)
        begin
            step(1);
            k++;
        end
        `CHK(state_q, st)
    endtask : wait_st
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic t_powerup;
        #1 arst_n = 1'b0;
        step(3);
        `CHK(power_q, 6'b111000)
        `CHK(hostio_q, 9'h000)
        arst_n = 1'b1;
        core_supply_ok = 1'b1;
        wait_st(psc_pkg::PSC_ST_STANDBY, 300);
        `CHK(power_q, 6'b111001)
        $display("powerup done");
    endtask : t_powerup
    task automatic t_wake;
        u_host.frame({psc_pkg::PFX_WRITE, 22'h0});
        step(20);
        `CHK(state_q, psc_pkg::PSC_ST_STANDBY)
        u_host.frame({psc_pkg::PFX_UNDEF, 22'h0});
        u_host.frame(cmd(psc_pkg::CMD_SLEEP));
        step(20);
        `CHK(state_q, psc_pkg::PSC_ST_STANDBY)
        u_host.frame(WAKE);
        wait_st(psc_pkg::PSC_ST_ACTIVE, 20);
        `CHK(power_q, 6'b111111)
        panel_in = 23'h12345;
        keep_in = 11'h2a5;
        step(2);
        `CHK(panel_q, panel_in)
        `CHK(hostio_q, hostio_in)
        $display("wake done");
    endtask : t_wake
    task automatic t_sleep;
        panel_in.pclk = 1'b0;
        keep_in.audio = 1'b0;
        keep_in.backlight = 1'b0;
        step(2);
        exp_p = panel_in;
        exp_k = keep_in;
        u_host.frame(cmd(psc_pkg::CMD_SLEEP));
        wait_st(psc_pkg::PSC_ST_SLEEP, 20);
        `CHK(power_q, 6'b100001)
        panel_in = ~panel_in;
        keep_in = ~keep_in;
        step(4);
        `CHK(panel_q, exp_p)
        `CHK(keep_q, exp_k)
        u_host.frame(WAKE);
        wait_st(psc_pkg::PSC_ST_ACTIVE, 20);
        #2000;
        $display("sleep done");
    endtask : t_sleep
    task automatic t_pwrdn;
        u_host.frame(cmd(psc_pkg::CMD_STANDBY));
        wait_st(psc_pkg::PSC_ST_STANDBY, 20);
        u_host.frame(WAKE);
        wait_st(psc_pkg::PSC_ST_ACTIVE, 20);
        exp_k = keep_in;
        u_host.frame(cmd(psc_pkg::CMD_PWRDOWN));
        wait_st(psc_pkg::PSC_ST_PWRDN, 20);
        `CHK(power_q.reg_en, 1'b0)
        keep_in = ~keep_in;
        step(2);
        `CHK(panel_q, 23'h0)
        `CHK(keep_q, exp_k)
        u_host.frame(WAKE);
        step(20);
        `CHK(power_q.reg_en, 1'b0)
        powerdown_pin_low_n = 1'b0;
        step(HOLD + 10);
        powerdown_pin_low_n = 1'b1;
        wait_st(psc_pkg::PSC_ST_WAKE, 10);
        `CHK(power_q.core_rst_n, 1'b0)
        `CHK(power_q.reg_en, 1'b1)
        wait_st(psc_pkg::PSC_ST_STANDBY, 300);
        $display("powerdown done");
    endtask : t_pwrdn
    task automatic t_pin;
        u_host.frame(WAKE);
        wait_st(psc_pkg::PSC_ST_ACTIVE, 20);
        powerdown_pin_low_n = 1'b0;
        wait_st(psc_pkg::PSC_ST_PWRDN, 10);
        `CHK(power_q.reg_en, 1'b1)
        step(HOLD + 10);
        `CHK(power_q.reg_en, 1'b0)
        osc_pll_ready = 1'b0;
        powerdown_pin_low_n = 1'b1;
        wait_st(psc_pkg::PSC_ST_STANDBY, 300);
        osc_pll_ready = 1'b1;
        $display("pin done");
    endtask : t_pin
    initial
    begin
        #400000;
        errors++;
        finish_test();
    end
    initial
    begin
        t_powerup();
        t_wake();
        t_sleep();
        t_pwrdn();
        t_pin();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
